// ---- rtl/epc_ctrl.sv ----
// module: host-side controller that reads, identifies and programs the EPROM
`timescale 1ns/100ps
module epc_ctrl import epc_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic [1:0] cmd_i,
    input wire logic short_alg_i,
    input wire logic id_sel_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [DATA_W-1:0] data_lines_i,
    output logic [DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic chip_sel_n_o,
    output logic out_gate_n_o,
    output logic program_strobe_n_o,
    output logic vpp_on_o,
    output logic vcc_prog_o,
    output logic id_mode_high_voltage_line_o,
    output logic busy_o,
    output logic done_o,
    output logic fail_o,
    output logic parity_err_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic [PCNT_W-1:0] pulses_o
);
    ////////////////////////////////////////////////////////////////////////
    epc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [PCNT_W-1:0] pcnt;
    logic [PCNT_W-1:0] fcnt;
    logic [1:0] cmd;
    logic alg_short;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            din_s1 <= 8'h00;
            din_s2 <= 8'h00;
        end else begin
            din_s1 <= data_lines_i;
            din_s2 <= din_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire cnt_end = (cnt == '0);
    wire match = (din_s2 == wdata);
    wire [PCNT_W-1:0] max_p = alg_short ? PCNT_W'(SHORT_MAX_PULSES) : PCNT_W'(PRIME_MAX_PULSES);
    wire [CNT_W-1:0] pulse_len = alg_short ? CNT_W'(SHORT_PULSE_CYC - 1) : CNT_W'(PRIME_PULSE_CYC - 1);
    wire odd_ok = ^din_s2;
    wire reading = (state == EPC_VSET) || (state == EPC_VCHK) || (state == EPC_READ);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= EPC_IDLE;
            cnt <= '0;
            pcnt <= '0;
            fcnt <= '0;
            cmd <= CMD_READ;
            alg_short <= 1'b0;
            wdata <= 8'h00;
            mem_addr_o <= '0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            parity_err_o <= 1'b0;
            rdata_o <= 8'h00;
            pulses_o <= '0;
        end else begin
            done_o <= 1'b0;
            case (state)
                EPC_IDLE: begin
                    if (req_i) begin
                        cmd <= cmd_i;
                        alg_short <= short_alg_i;
                        wdata <= wdata_i;
                        fail_o <= 1'b0;
                        parity_err_o <= 1'b0;
                        pcnt <= '0;
                        fcnt <= '0;
                        cnt <= CNT_W'(SETUP_CYC - 1);
                        mem_addr_o <= (cmd_i == CMD_ID) ? {{(ADDR_W-1){1'b0}}, id_sel_i} : addr_i;
                        state <= (cmd_i == CMD_PROG) ? EPC_SETUP : EPC_READ;
                    end
                end
                EPC_SETUP: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_end && (fcnt != '0)) begin
                        // final pulse also waits out the data setup time
                        cnt <= CNT_W'(PRIME_PULSE_CYC - 1);
                        state <= EPC_FINAL;
                    end else if (cnt_end) begin
                        cnt <= pulse_len;
                        pcnt <= pcnt + 1'b1;
                        state <= EPC_PULSE;
                    end
                end
                EPC_PULSE: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_end) begin
                        cnt <= CNT_W'(SETUP_CYC - 1);
                        state <= EPC_VSET;
                    end
                end
                EPC_VSET: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_end) state <= EPC_VCHK;
                end
                EPC_VCHK: begin
                    cnt <= CNT_W'(SETUP_CYC - 1);
                    if (match && !alg_short) begin
                        fcnt <= PCNT_W'(FINAL_MULT) * pcnt;
                        state <= EPC_SETUP;
                    end else if (match) begin
                        state <= EPC_DONE;
                    end else if (pcnt >= max_p) begin
                        fail_o <= 1'b1;
                        state <= EPC_DONE;
                    end else begin
                        state <= EPC_SETUP;
                    end
                end
                EPC_FINAL: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_end) begin
                        cnt <= CNT_W'(PRIME_PULSE_CYC - 1);
                        fcnt <= fcnt - 1'b1;
                        if (fcnt == PCNT_W'(1)) state <= EPC_DONE;
                    end
                end
                EPC_READ: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_end) begin
                        rdata_o <= din_s2;
                        parity_err_o <= (cmd == CMD_ID) && !odd_ok;
                        state <= EPC_DONE;
                    end
                end
                EPC_DONE: begin
                    pulses_o <= pcnt;
                    done_o <= 1'b1;
                    state <= EPC_IDLE;
                end
                default: state <= EPC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire prog_phase = (state == EPC_SETUP) || (state == EPC_PULSE) || (state == EPC_FINAL);
    wire pulse_on = (state == EPC_PULSE) || (state == EPC_FINAL);
    wire prog_cmd = (state != EPC_IDLE) && (state != EPC_READ) && (state != EPC_DONE);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chip_sel_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            program_strobe_n_o <= 1'b1;
            data_lines_oe_o <= 1'b0;
            data_lines_o <= 8'h00;
            vpp_on_o <= 1'b0;
            vcc_prog_o <= 1'b0;
            id_mode_high_voltage_line_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            chip_sel_n_o <= (state == EPC_IDLE) || (state == EPC_DONE);
            out_gate_n_o <= !reading;
            program_strobe_n_o <= !pulse_on;
            data_lines_oe_o <= prog_phase;
            data_lines_o <= wdata;
            vpp_on_o <= prog_cmd;
            vcc_prog_o <= prog_cmd;
            id_mode_high_voltage_line_o <= (state == EPC_READ) && (cmd == CMD_ID);
            busy_o <= (state != EPC_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_no_contention;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        data_lines_oe_o |-> out_gate_n_o;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("data driven while output gate low");

    property p_strobe_needs_sel;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !program_strobe_n_o |-> !chip_sel_n_o && out_gate_n_o && vpp_on_o && data_lines_oe_o;
    endproperty
    a_strobe_needs_sel: assert property (p_strobe_needs_sel) else $error("strobe without program setup");

    property p_verify_vpp;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (state == EPC_VCHK) |-> vpp_on_o && !out_gate_n_o && program_strobe_n_o;
    endproperty
    a_verify_vpp: assert property (p_verify_vpp) else $error("verify without vpp or gate");

    property p_short_limit;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        alg_short && prog_cmd |-> pcnt <= PCNT_W'(SHORT_MAX_PULSES);
    endproperty
    a_short_limit: assert property (p_short_limit) else $error("short pulse count exceeded");

    property p_prime_limit;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !alg_short && prog_cmd |-> pcnt <= PCNT_W'(PRIME_MAX_PULSES);
    endproperty
    a_prime_limit: assert property (p_prime_limit) else $error("prime pulse count exceeded");

    // short pulses are measured by a counter, not by a delay
    logic [CNT_W-1:0] strobe_low_run;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strobe_low_run <= '0;
        end else begin
            strobe_low_run <= program_strobe_n_o ? '0 : strobe_low_run + 1'b1;
        end
    end

    sequence s_short_pulse_end;
        $rose(program_strobe_n_o) && alg_short;
    endsequence
    property p_short_len;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        s_short_pulse_end |-> strobe_low_run == CNT_W'(SHORT_PULSE_CYC);
    endproperty
    a_short_len: assert property (p_short_len) else $error("short pulse length wrong");

    property p_final_len;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(state == EPC_FINAL) |-> fcnt == PCNT_W'(FINAL_MULT) * pcnt;
    endproperty
    a_final_len: assert property (p_final_len) else $error("final pulse length wrong");

    property p_id_pins;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        id_mode_high_voltage_line_o |-> !chip_sel_n_o && !out_gate_n_o && program_strobe_n_o && !vpp_on_o;
    endproperty
    a_id_pins: assert property (p_id_pins) else $error("id mode pins wrong");

    property p_idle_standby;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (state == EPC_IDLE) ##1 (state == EPC_IDLE) |-> chip_sel_n_o && !data_lines_oe_o;
    endproperty
    a_idle_standby: assert property (p_idle_standby) else $error("not in standby when idle");
endmodule // epc_ctrl

// ---- inc/epc_pkg.sv ----
// package: constants and types for the EPROM programmer controller
//
// Behaviour
// - only one memory drives the shared data lines; unselected ones are held off by chip select or output gate high.
// - to program, address and data are set with chip select low, output gate high and vpp on, then the strobe pulses low.
// - verify uses output gate low, chip select low, strobe high with vpp still applied, and the memory returns the byte.
// - the short-pulse algorithm applies 100 us pulses with a verify after each.
// - the short-pulse algorithm allows at most ten pulses per byte, then reports failure.
// - the standard algorithm applies 1 ms prime pulses with a verify after each, up to 25.
// - after a good verify the standard algorithm applies a final pulse of three ms per prime pulse used.
// - after programming, every location is read back at normal supply to confirm it.
// - locations may be programmed in any order, singly or in blocks.
// - with the id line at high voltage and other addresses low, the byte select line picks maker or part code.
package epc_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 125;
    localparam int SHORT_PULSE_US = 100;
    localparam int PRIME_PULSE_US = 1000;
    localparam int SETUP_US = 2;
    localparam int SHORT_PULSE_CYC = SHORT_PULSE_US * CLK_MHZ;
    localparam int PRIME_PULSE_CYC = PRIME_PULSE_US * CLK_MHZ;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int SHORT_MAX_PULSES = 10;
    localparam int PRIME_MAX_PULSES = 25;
    localparam int FINAL_MULT = 3;
    localparam int CNT_W = 18;
    localparam int PCNT_W = 7;
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_ID = 2'h2;

    typedef enum logic [2:0] {
        EPC_IDLE = 3'b000,
        EPC_SETUP = 3'b001,
        EPC_PULSE = 3'b010,
        EPC_VSET = 3'b011,
        EPC_VCHK = 3'b100,
        EPC_FINAL = 3'b101,
        EPC_READ = 3'b110,
        EPC_DONE = 3'b111
    } epc_state_t;
endpackage

// ---- test/epc_mem_model.sv ----
// memory device model: mode decode, byte program, id codes
`timescale 1ns/100ps
module epc_mem_model import epc_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = 8'h07, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h0B // arbitrary value
) (
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic chip_sel_n_i,
    input wire logic out_gate_n_i,
    input wire logic program_strobe_n_i,
    input wire logic vpp_on_i,
    input wire logic id_hv_i,
    input wire logic slow_i,
    input wire logic bad_par_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o
);
    logic [7:0] mem [0:2**ADDR_W-1];
    logic [7:0] last = 8'h00;
    logic [ADDR_W-1:0] last_addr = '0;
    int hits = 0;
    wire drive = !chip_sel_n_i && !out_gate_n_i && program_strobe_n_i;
    wire [7:0] id_code = addr_i[0] ? PART_CODE : MAKER_CODE;
    wire [7:0] code = bad_par_i ? (id_code ^ 8'h80) : id_code;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    always @* begin
        if (drive) last = id_hv_i ? code : mem[addr_i];
    end
    // released lines show the inverse of the last byte, not a held value
    assign data_o = drive ? last : ~last;
    // write as the strobe falls; the end of a short or prime pulse coincides with gate and data turning round
    always @(negedge program_strobe_n_i) begin
        if (!chip_sel_n_i && out_gate_n_i && vpp_on_i) begin
            hits = (addr_i == last_addr) ? hits + 1 : 1;
            last_addr = addr_i;
            if (!slow_i || hits >= 2) mem[addr_i] = mem[addr_i] & data_i;
        end
    end
endmodule // epc_mem_model

// ---- test/testbench.sv ----
// testbench: self-checking bench for the EPROM programmer controller
`timescale 1ns/100ps
module testbench import epc_pkg::*;;
    localparam logic [7:0] MAKER = 8'h07; // arbitrary value
    localparam logic [7:0] PART = 8'h0B; // arbitrary value
    typedef struct {logic [1:0] cmd; logic [7:0] val; logic par; int pulses;} epc_note_t;
    logic clk_sys_i = 0, nrst_i = 0, req_i = 0, short_alg_i = 1, id_sel_i = 0, slow = 0, bad_par = 0;
    logic [1:0] cmd_i = 0;
    logic [ADDR_W-1:0] addr_i = 0, mem_addr_o, a1, a2;
    logic [DATA_W-1:0] wdata_i = 0, data_lines_o, mem_q, rdata_o, d1, d2;
    logic data_lines_oe_o, chip_sel_n_o, out_gate_n_o, program_strobe_n_o, vpp_on_o, vcc_prog_o;
    logic id_hv, busy_o, done_o, fail_o, parity_err_o;
    logic [PCNT_W-1:0] pulses_o;
    int err_count = 0, samples_checked = 0, cycles = 0, low_cnt = 0, pulses_seen = 0;
    epc_note_t notes[$];
    epc_note_t n;
    wire logic [DATA_W-1:0] data_lines = data_lines_oe_o ? data_lines_o : mem_q;
    epc_ctrl i_epc_ctrl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_i), .cmd_i(cmd_i),
        .short_alg_i(short_alg_i), .id_sel_i(id_sel_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .data_lines_i(data_lines), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
        .mem_addr_o(mem_addr_o), .chip_sel_n_o(chip_sel_n_o), .out_gate_n_o(out_gate_n_o),
        .program_strobe_n_o(program_strobe_n_o), .vpp_on_o(vpp_on_o), .vcc_prog_o(vcc_prog_o),
        .id_mode_high_voltage_line_o(id_hv), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o),
        .parity_err_o(parity_err_o), .rdata_o(rdata_o), .pulses_o(pulses_o));
    epc_mem_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_epc_mem_model (.addr_i(mem_addr_o),
        .chip_sel_n_i(chip_sel_n_o), .out_gate_n_i(out_gate_n_o), .program_strobe_n_i(program_strobe_n_o),
        .vpp_on_i(vpp_on_o), .id_hv_i(id_hv), .slow_i(slow), .bad_par_i(bad_par), .data_i(data_lines),
        .data_o(mem_q));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // every command also repeats req while busy; it must be ignored
    task automatic run_cmd(string tname, logic [1:0] cmd, logic sel, logic [ADDR_W-1:0] a,
                           logic [7:0] d, epc_note_t note);
        int k;
        chk("standby_cs", chip_sel_n_o, 1);
        chk("idle_busy", busy_o, 0);
        pulses_seen = 0;
        notes.push_back(note);
        cmd_i = cmd;
        id_sel_i = sel;
        addr_i = a;
        wdata_i = d;
        // standard pulses run far too long here, so programs use short pulses
        short_alg_i = 1'($urandom) | (cmd == CMD_PROG);
        req_i = 1;
        @(posedge clk_sys_i);
        #1 req_i = 0;
        repeat (4) @(posedge clk_sys_i);
        #1 req_i = 1;
        chk("busy", busy_o, 1);
        chk("vpp_mid", vpp_on_o, cmd == CMD_PROG);
        chk("vcc_mid", vcc_prog_o, cmd == CMD_PROG);
        chk("drive_mid", data_lines_oe_o, cmd == CMD_PROG);
        chk("gate_mid", out_gate_n_o, cmd == CMD_PROG);
        chk("id_line", id_hv, cmd == CMD_ID);
        chk("addr_pins", mem_addr_o, (cmd == CMD_ID) ? ADDR_W'(sel) : a);
        @(posedge clk_sys_i);
        #1 req_i = 0;
        for (k = 0; k < 40000 && done_o !== 1'b1; k++) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (done_o !== 1'b1) chk("done_seen", 0, 1);
        @(posedge clk_sys_i);
        #1 $display("test %s finished", tname);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i) begin
        #2 cycles++;
        if (program_strobe_n_o === 1'b0) low_cnt++;
        else if (low_cnt != 0) begin
            chk("pulse_len", low_cnt, SHORT_PULSE_CYC);
            pulses_seen++;
            low_cnt = 0;
        end
        if (done_o === 1'b1 && notes.size() == 0) chk("extra_done", 1, 0);
        else if (done_o === 1'b1) begin
            n = notes.pop_front();
            chk("pulses_o", pulses_o, n.pulses);
            if (n.cmd == CMD_PROG) begin
                chk("fail", fail_o, 0);
                chk("pulses", pulses_seen, n.pulses);
            end else begin
                chk("rdata", rdata_o, n.val);
                chk("parity_err", parity_err_o, n.par);
                chk("vpp_on", vpp_on_o, 0);
            end
        end
        if (cycles == 90000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(25));
        a1 = 14'($urandom);
        a2 = ~a1;
        d1 = 8'($urandom) & 8'h7F;
        d2 = 8'($urandom) & 8'hFE;
        repeat (2) @(posedge clk_sys_i);
        #1 nrst_i = 1;
        run_cmd("read_erased", CMD_READ, 0, a1, 0, '{CMD_READ, 8'hFF, 0, 0});
        run_cmd("id_maker", CMD_ID, 0, 0, 0, '{CMD_ID, MAKER, 0, 0});
        run_cmd("id_part", CMD_ID, 1, 0, 0, '{CMD_ID, PART, 0, 0});
        bad_par = 1;
        run_cmd("id_bad_parity", CMD_ID, 0, 0, 0, '{CMD_ID, MAKER ^ 8'h80, 1, 0});
        bad_par = 0;
        run_cmd("prog_one", CMD_PROG, 0, a1, d1, '{CMD_PROG, 0, 0, 1});
        run_cmd("verify_one", CMD_READ, 0, a1, 0, '{CMD_READ, d1, 0, 0});
        slow = 1;
        run_cmd("prog_two", CMD_PROG, 0, a2, d2, '{CMD_PROG, 0, 0, 2});
        slow = 0;
        run_cmd("verify_two", CMD_READ, 0, a2, 0, '{CMD_READ, d2, 0, 0});
        run_cmd("verify_kept", CMD_READ, 0, a1, 0, '{CMD_READ, d1, 0, 0});
        end_sim();
    end
endmodule // testbench
